// File: warn_flags_pkg.sv
package warn_flags_pkg;
	localparam int unsigned CAP_WIDTH = 16;
	localparam logic signed [15:0] FINAL_SET_DISABLED = 16'shFFFF;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_INIT_SET = 8'h04;
	localparam logic [7:0] ADDR_INIT_CLEAR = 8'h08;
	localparam logic [7:0] ADDR_FINAL_SET = 8'h0C;
	localparam logic [7:0] ADDR_FINAL_CLEAR = 8'h10;
	localparam logic [7:0] ADDR_CAPACITY = 8'h14;
	localparam logic [7:0] ADDR_FLAGS = 8'h18;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
	localparam int unsigned ADDR_BITS = 8;
	localparam int unsigned NUM_FLAGS = 4;
	localparam int unsigned FLAG_INIT = 0;
	localparam int unsigned FLAG_FINAL = 1;
	localparam int unsigned FLAG_SHORT = 2;
	localparam int unsigned FLAG_TAB = 3;
	localparam int unsigned CTRL_SHORT_CLR = 0;
	localparam int unsigned CTRL_TAB_CLR = 1;
	localparam logic signed [15:0] INIT_SET_RESET = 16'sh0096;
	localparam logic signed [15:0] INIT_CLEAR_RESET = 16'sh00AF;
	localparam logic signed [15:0] FINAL_SET_RESET = 16'sh004B;
	localparam logic signed [15:0] FINAL_CLEAR_RESET = 16'sh0064;
	localparam logic signed [15:0] CAP_RESET = 16'sh03E8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: battery_charge_warning_flags.sv
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Contract
// - set initial flag below initial set level
// - hold initial flag until above clear
// - set final flag below final set level
// - final set level -1 disables setting
// - clear final flag only when set, above clear
// - all levels compared in mAh units
// - relaxed-voltage short detection sets short flag
// - tab-loss detection sets tab flag
// - status word shows all four flags
module battery_charge_warning_flags import warn_flags_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// capacity estimate from the gauge core
	input wire logic [CAP_WIDTH-1:0] remaining_capacity_estimate,
	input wire logic capacity_update,
	// detector events
	input wire logic relaxed_short_detected,
	input wire logic tab_loss_detected,
	// flags
	output logic initial_low_capacity_flag,
	output logic final_discharge_warning_flag,
	output logic internal_short_flag,
	output logic tab_disconnect_flag,
	output logic irq,
	// axi4-lite write address
	input wire logic [ADDR_BITS-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [ADDR_BITS-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	logic signed [15:0] init_set_q;
	logic signed [15:0] init_clear_q;
	logic signed [15:0] final_set_q;
	logic signed [15:0] final_clear_q;
	logic signed [15:0] cap_q;
	logic init_flag_q;
	logic final_flag_q;
	logic short_flag_q;
	logic tab_flag_q;
	logic [NUM_FLAGS-1:0] flags_q;
	logic [NUM_FLAGS-1:0] irq_mask_q;
	logic [NUM_FLAGS-1:0] flags_rise;
	// one flop per bit lives in the generate below; this net only gathers them
	wire logic [NUM_FLAGS-1:0] irq_status_q;
	logic [ADDR_BITS-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic aw_held_q;
	logic w_held_q;
	logic do_write;
	logic do_read;
	logic short_clr_pulse;
	logic tab_clr_pulse;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] be);
		merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic is_mapped(input logic [ADDR_BITS-1:0] a);
		case (a)
			ADDR_CTRL, ADDR_INIT_SET, ADDR_INIT_CLEAR, ADDR_FINAL_SET, ADDR_FINAL_CLEAR,
			ADDR_CAPACITY, ADDR_FLAGS, ADDR_IRQ_STATUS, ADDR_IRQ_MASK: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	// single-bit control words only honour the low byte lane
	function automatic logic low_lane_write(input logic [ADDR_BITS-1:0] a,
			input logic [ADDR_BITS-1:0] target, input logic go, input logic [3:0] be);
		low_lane_write = go && a == target && be[0];
	endfunction

	// write channel: address and data captured in either order
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
		end else if (do_write) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awaddr_q <= s_axi_awaddr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
		end else if (do_write) begin
			w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end
	end

	// response costs a cycle but keeps the decode off the ready path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bresp <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// thresholds in mAh, same signed unit as the capacity estimate
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_set_q <= INIT_SET_RESET;
		end else if (do_write && awaddr_q == ADDR_INIT_SET) begin
			init_set_q <= merge16(init_set_q, wdata_q, wstrb_q);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_clear_q <= INIT_CLEAR_RESET;
		end else if (do_write && awaddr_q == ADDR_INIT_CLEAR) begin
			init_clear_q <= merge16(init_clear_q, wdata_q, wstrb_q);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			final_set_q <= FINAL_SET_RESET;
		end else if (do_write && awaddr_q == ADDR_FINAL_SET) begin
			final_set_q <= merge16(final_set_q, wdata_q, wstrb_q);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			final_clear_q <= FINAL_CLEAR_RESET;
		end else if (do_write && awaddr_q == ADDR_FINAL_CLEAR) begin
			final_clear_q <= merge16(final_clear_q, wdata_q, wstrb_q);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_q <= '0;
		end else if (low_lane_write(awaddr_q, ADDR_IRQ_MASK, do_write, wstrb_q)) begin
			irq_mask_q <= wdata_q[NUM_FLAGS-1:0];
		end
	end

	assign short_clr_pulse = low_lane_write(awaddr_q, ADDR_CTRL, do_write, wstrb_q)
		&& wdata_q[CTRL_SHORT_CLR];
	assign tab_clr_pulse = low_lane_write(awaddr_q, ADDR_CTRL, do_write, wstrb_q)
		&& wdata_q[CTRL_TAB_CLR];

	// latest estimate, kept for readback
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_q <= CAP_RESET;
		end else if (capacity_update) begin
			cap_q <= remaining_capacity_estimate;
		end
	end

	// comparisons run on the incoming estimate so flags follow the same update
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_flag_q <= 1'b0;
		end else if (capacity_update) begin
			if ($signed(remaining_capacity_estimate) < init_set_q) begin
				init_flag_q <= 1'b1;
			end else if ($signed(remaining_capacity_estimate) > init_clear_q) begin
				init_flag_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			final_flag_q <= 1'b0;
		end else if (capacity_update) begin
			if (final_set_q != FINAL_SET_DISABLED
					&& $signed(remaining_capacity_estimate) < final_set_q) begin
				final_flag_q <= 1'b1;
			end else if (final_flag_q
					&& $signed(remaining_capacity_estimate) > final_clear_q) begin
				final_flag_q <= 1'b0;
			end
		end
	end

	// detector flags are sticky; a detection in the clearing cycle wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			short_flag_q <= 1'b0;
		end else if (relaxed_short_detected) begin
			short_flag_q <= 1'b1;
		end else if (short_clr_pulse) begin
			short_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tab_flag_q <= 1'b0;
		end else if (tab_loss_detected) begin
			tab_flag_q <= 1'b1;
		end else if (tab_clr_pulse) begin
			tab_flag_q <= 1'b0;
		end
	end

	// status word layout gathered in one place
	always_comb begin
		flags_q = '0;
		flags_q[FLAG_INIT] = init_flag_q;
		flags_q[FLAG_FINAL] = final_flag_q;
		flags_q[FLAG_SHORT] = short_flag_q;
		flags_q[FLAG_TAB] = tab_flag_q;
	end

	assign initial_low_capacity_flag = init_flag_q;
	assign final_discharge_warning_flag = final_flag_q;
	assign internal_short_flag = short_flag_q;
	assign tab_disconnect_flag = tab_flag_q;

	// events are rising edges of each flag, seen one cycle after the flag sets
	logic [NUM_FLAGS-1:0] flags_prev_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_prev_q <= '0;
		end else begin
			flags_prev_q <= flags_q;
		end
	end

	assign flags_rise = flags_q & ~flags_prev_q;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_irq
			logic status_q;
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					status_q <= 1'b0;
				end else if (flags_rise[gi]) begin
					status_q <= 1'b1;
				end else if (low_lane_write(awaddr_q, ADDR_IRQ_STATUS, do_write, wstrb_q)
						&& wdata_q[gi]) begin
					status_q <= 1'b0;
				end
			end
			assign irq_status_q[gi] = status_q;
		end
	endgenerate

	assign irq = |(irq_status_q & irq_mask_q);

	// read channel: one cycle from address to data
	assign s_axi_arready = !s_axi_rvalid;
	assign do_read = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OKAY;
		end else if (do_read) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// data loads only on an accepted address, so it stands until rready
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rdata <= '0;
		end else if (do_read) begin
			case (s_axi_araddr)
				ADDR_INIT_SET: s_axi_rdata <= {16'h0000, init_set_q};
				ADDR_INIT_CLEAR: s_axi_rdata <= {16'h0000, init_clear_q};
				ADDR_FINAL_SET: s_axi_rdata <= {16'h0000, final_set_q};
				ADDR_FINAL_CLEAR: s_axi_rdata <= {16'h0000, final_clear_q};
				ADDR_CAPACITY: s_axi_rdata <= {16'h0000, cap_q};
				ADDR_FLAGS: s_axi_rdata <= {28'h0000000, flags_q};
				ADDR_IRQ_STATUS: s_axi_rdata <= {28'h0000000, irq_status_q};
				ADDR_IRQ_MASK: s_axi_rdata <= {28'h0000000, irq_mask_q};
				default: s_axi_rdata <= 32'h00000000;
			endcase
		end
	end

endmodule // battery_charge_warning_flags

// File: battery_charge_warning_flags_checker.sv
`timescale 1ns/1ps
module battery_charge_warning_flags_checker (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// events
	input wire logic capacity_update,
	input wire logic relaxed_short_detected,
	input wire logic tab_loss_detected,
	// flags
	input wire logic initial_low_capacity_flag,
	input wire logic final_discharge_warning_flag,
	input wire logic internal_short_flag,
	input wire logic tab_disconnect_flag,
	// bus handshakes
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_short_sets: assert property (
		relaxed_short_detected |=> internal_short_flag) else $error("short flag missed");
	a_tab_sets: assert property (
		tab_loss_detected |=> tab_disconnect_flag) else $error("tab flag missed");
	a_init_moves: assert property (
		!capacity_update |=> $stable(initial_low_capacity_flag)) else $error("init flag moved");
	a_final_moves: assert property (
		$changed(final_discharge_warning_flag) |-> $past(capacity_update))
		else $error("final flag moved");
	a_write_refused: assert property (
		s_axi_bvalid |-> !s_axi_awready) else $error("awready during response");
	a_read_refused: assert property (
		s_axi_rvalid |-> !s_axi_arready) else $error("arready during response");
	a_read_done: assert property (
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
	a_write_done: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
endmodule // battery_charge_warning_flags_checker

bind battery_charge_warning_flags battery_charge_warning_flags_checker chk (.aclk, .aresetn,
	.capacity_update, .relaxed_short_detected, .tab_loss_detected,
	.initial_low_capacity_flag, .final_discharge_warning_flag, .internal_short_flag,
	.tab_disconnect_flag, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready);

// File: host_axi.sv
`timescale 1ns/1ps
module host_axi import warn_flags_pkg::*; (
	// clock
	input wire logic aclk,
	// write channels
	output logic [ADDR_BITS-1:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	// read channels
	output logic [ADDR_BITS-1:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
	end
	task automatic wr(input logic [ADDR_BITS-1:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			// released payload is scrambled, never left showing
			if (s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [ADDR_BITS-1:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		#1;
	endtask
endmodule // host_axi

// File: battery_charge_warning_flags_bench.sv
`timescale 1ns/1ps
module battery_charge_warning_flags_bench;
	import warn_flags_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [CAP_WIDTH-1:0] remaining_capacity_estimate = 16'h0000;
	logic capacity_update = 1'b0;
	logic relaxed_short_detected = 1'b0;
	logic tab_loss_detected = 1'b0;
	logic initial_low_capacity_flag, final_discharge_warning_flag;
	logic internal_short_flag, tab_disconnect_flag, irq;
	logic [ADDR_BITS-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	always #5 aclk = ~aclk;
	battery_charge_warning_flags dut (.aclk, .aresetn, .remaining_capacity_estimate,
		.capacity_update, .relaxed_short_detected, .tab_loss_detected,
		.initial_low_capacity_flag, .final_discharge_warning_flag, .internal_short_flag,
		.tab_disconnect_flag, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	host_axi host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	task automatic stop_test;
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		host.rd(a, d, r);
		check(what, d, exp);
	endtask
	// one update; flags settle at the second edge
	task automatic cap(input logic [15:0] v, input logic [1:0] exp);
		@(posedge aclk);
		remaining_capacity_estimate <= v;
		capacity_update <= 1'b1;
		@(posedge aclk);
		capacity_update <= 1'b0;
		#1;
		check("flags", {30'h0, final_discharge_warning_flag, initial_low_capacity_flag},
			{30'h0, exp});
	endtask
	task automatic test_reset;
		rdc("init_set", ADDR_INIT_SET, 32'h00000096);
		rdc("init_clear", ADDR_INIT_CLEAR, 32'h000000AF);
		rdc("final_set", ADDR_FINAL_SET, 32'h0000004B);
		rdc("final_clear", ADDR_FINAL_CLEAR, 32'h00000064);
		rdc("capacity", ADDR_CAPACITY, 32'h000003E8);
		rdc("mask", ADDR_IRQ_MASK, 32'h00000000);
		rdc("flags", ADDR_FLAGS, 32'h00000000);
	endtask
	task automatic test_initial;
		cap(16'h0096, 2'h0);
		cap(16'h0095, 2'h1);
		cap(16'h00AF, 2'h1);
		rdc("flags", ADDR_FLAGS, 32'h00000001);
		cap(16'h00B0, 2'h0);
	endtask
	task automatic test_final;
		cap(16'h004A, 2'h3);
		cap(16'h0064, 2'h3);
		cap(16'h0065, 2'h1);
		host.wr(ADDR_FINAL_SET, 32'h0000FFFF);
		rdc("final_set", ADDR_FINAL_SET, 32'h0000FFFF);
		cap(16'hFFF0, 2'h1);
	endtask
	task automatic test_events;
		logic [31:0] d;
		logic [1:0] r;
		host.wr(ADDR_IRQ_STATUS, 32'h0000000F);
		host.wr(ADDR_IRQ_MASK, 32'h0000000C);
		check("irq", 32'(irq), 32'h0);
		@(posedge aclk);
		relaxed_short_detected <= 1'b1;
		@(posedge aclk);
		relaxed_short_detected <= 1'b0;
		#1;
		check("short", 32'(internal_short_flag), 32'h1);
		@(posedge aclk);
		#1;
		check("irq", 32'(irq), 32'h1);
		rdc("status", ADDR_IRQ_STATUS, 32'h00000004);
		host.wr(ADDR_IRQ_STATUS, 32'h00000004);
		check("irq", 32'(irq), 32'h0);
		host.wr(ADDR_CTRL, 32'h00000001);
		check("short", 32'(internal_short_flag), 32'h0);
		@(posedge aclk);
		tab_loss_detected <= 1'b1;
		@(posedge aclk);
		tab_loss_detected <= 1'b0;
		rdc("flags", ADDR_FLAGS, 32'h00000009);
		host.rd(8'h40, d, r);
		check("unmapped", {r, d[29:0]}, {RESP_SLVERR, 30'h0});
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		test_reset;
		test_initial;
		test_final;
		test_events;
		stop_test;
	end
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			stop_test;
		end
	end
endmodule // battery_charge_warning_flags_bench
